// [bench/spi_flash_pd_id_chk.sv]
// Purpose: port assertions for spi_flash_pd_id
// Assumes: bound to the top module, PUW_CYCLES handed on
// Notes:   bounds allow two cycles for the pin synchroniser
`timescale 1ns/1ps
`include "spi_flash_id_defs.svh"
module spi_flash_pd_id_chk #(
  parameter int PUW_CYCLES = `PUW_CYCLES
) (
  input wire logic clk_sys,      // system clock
  input wire logic rst,          // reset, high
  input wire logic spi_cs_n,     // chip select
  input wire logic spi_sck,      // serial clock
  input wire logic busy,         // write cycle running
  input wire logic spi_miso,     // data out
  input wire logic spi_miso_oe,  // data out enable
  input wire logic powered_down, // low-power state
  input wire logic write_ready   // writes allowed
);
  int unsigned cyc;
  int unsigned rel_len;
  // deselected cycles in the low-power state; a new frame restarts the count,
  // so entry time cannot hide a release that comes too early
  always_ff @(posedge clk_sys)
  begin
    cyc     <= rst ? 0 : ((cyc < 32'h7fffffff) ? cyc + 1 : cyc);
    rel_len <= (rst || spi_cs_n == 1'b0 || !powered_down) ? 0 : rel_len + 1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_reset_quiet;
    @(posedge clk_sys) disable iff (1'b0)
    rst |=> !spi_miso_oe && !powered_down && !write_ready;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("active after reset");
  property p_oe_release;
    $rose(spi_cs_n) |-> ##[1:5] !spi_miso_oe;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("data out held");
  property p_oe_needs_cs;
    $rose(spi_miso_oe) |-> !spi_cs_n;
  endproperty
  a_oe_needs_cs: assert property (p_oe_needs_cs) else $error("driven unselected");
  property p_miso_low_phase;
    $changed(spi_miso) |-> !spi_sck;
  endproperty
  a_miso_low_phase: assert property (p_miso_low_phase) else $error("data moved, sck high");
  property p_pd_after_cs;
    $rose(powered_down) |-> $past(spi_cs_n, 3);
  endproperty
  a_pd_after_cs: assert property (p_pd_after_cs) else $error("entry while selected");
  property p_pd_min_len;
    $fell(powered_down) |-> rel_len >= `RES2_CYCLES;
  endproperty
  a_pd_min_len: assert property (p_pd_min_len) else $error("release too early");
  property p_pd_busy;
    powered_down && busy |=> powered_down;
  endproperty
  a_pd_busy: assert property (p_pd_busy) else $error("released while busy");
  property p_wr_early;
    write_ready |-> cyc >= PUW_CYCLES;
  endproperty
  a_wr_early: assert property (p_wr_early) else $error("write ready too early");
  property p_wr_late;
    cyc == PUW_CYCLES + 4 |-> write_ready;
  endproperty
  a_wr_late: assert property (p_wr_late) else $error("write ready too late");
endmodule : spi_flash_pd_id_chk

// [bench/spi_flash_pd_id_tb.sv]
// Purpose: self-checking bench of spi_flash_pd_id
// Assumes: 200 MHz clk_sys, host model on the serial pins
// Notes:   short write delay parameter keeps the run brief
`timescale 1ns/1ps
`include "spi_flash_id_defs.svh"
module spi_flash_pd_id_tb;
  import spi_flash_id_pkg::*;
  localparam int         PUW = 20;
  localparam logic [7:0] MK  = 8'h5a; // arbitrary code
  localparam logic [7:0] DV  = 8'h13; // arbitrary code
  localparam logic [7:0] MT  = 8'h30; // arbitrary code
  localparam logic [7:0] CP  = 8'h14; // arbitrary code
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        busy    = 1'b0;
  logic        spi_miso;
  logic        spi_miso_oe;
  logic        powered_down;
  logic        write_ready;
  logic [31:0] rx;
  spi_pins_s   pins;
  int          err_total  = 0;
  int          num_checks = 0;
  always #2.5 clk_sys = ~clk_sys;
  // undriven data out reads back inverted, so an ignored frame cannot pass as zeros
  spi_host_model host (.clk_sys(clk_sys), .miso(spi_miso_oe ? spi_miso : ~spi_miso),
    .pins(pins));
  spi_flash_pd_id #(.MAKER_ID(MK), .DEVICE_ID(DV), .MEM_TYPE(MT), .CAPACITY(CP),
    .PUW_CYCLES(PUW)) dut (.clk_sys(clk_sys), .rst(rst), .spi_cs_n(pins.cs_n),
    .spi_sck(pins.sck), .spi_mosi(pins.mosi), .busy(busy), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .powered_down(powered_down), .write_ready(write_ready));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : w
  task automatic t_power_up();
    chk({31'h0, powered_down}, 32'h0);
    chk({31'h0, write_ready}, 32'h0);
    w(PUW + 6);
    chk({31'h0, write_ready}, 32'h1);
  endtask : t_power_up
  task automatic t_std_id();
    host.frame({`OP_STD_ID, 24'h0}, 8, 24, rx);
    chk(rx, {8'h0, MK, MT, CP});
    chk({31'h0, spi_miso_oe}, 32'h0);
  endtask : t_std_id
  task automatic t_maker_dev();
    for (int a = 0; a < 2; a++)
    begin
      host.frame({`OP_MAKER_DEV_ID, 24'(a)}, 32, 32, rx);
      chk(rx, (a == 0) ? {MK, DV, MK, DV} : {DV, MK, DV, MK});
    end
  endtask : t_maker_dev
  task automatic t_release_id();
    host.frame({`OP_RELEASE_ID, 24'h0}, 32, 16, rx);
    chk(rx, {16'h0, DV, DV});
    busy = 1'b1;
    host.frame({`OP_RELEASE_ID, 24'h0}, 32, 8, rx);
    busy = 1'b0;
    chk(rx, 32'h000000ff);
  endtask : t_release_id
  task automatic t_power_down();
    host.frame({`OP_POWER_DOWN, 24'h0}, 9, 0, rx);
    chk({31'h0, powered_down}, 32'h0);
    host.frame({`OP_POWER_DOWN, 24'h0}, 8, 0, rx);
    chk({31'h0, powered_down}, 32'h1);
    w(`DP_CYCLES + 10);
    host.frame({`OP_STD_ID, 24'h0}, 8, 24, rx);
    chk(rx, 32'h00ffffff);
    busy = 1'b1;
    host.frame({`OP_RELEASE_ID, 24'h0}, 8, 0, rx);
    w(`RES1_CYCLES + 100);
    chk({31'h0, powered_down}, 32'h1);
    busy = 1'b0;
    host.frame({`OP_RELEASE_ID, 24'h0}, 8, 0, rx);
    w(`RES1_CYCLES / 2);
    chk({31'h0, powered_down}, 32'h1);
    w(`RES1_CYCLES / 2 + 100);
    chk({31'h0, powered_down}, 32'h0);
    host.frame({`OP_STD_ID, 24'h0}, 8, 24, rx);
    chk(rx, {8'h0, MK, MT, CP});
  endtask : t_power_down
  task automatic t_pd_with_id();
    host.frame({`OP_POWER_DOWN, 24'h0}, 8, 0, rx);
    w(`DP_CYCLES + 10);
    host.frame({`OP_RELEASE_ID, 24'h0}, 32, 8, rx);
    chk(rx, {24'h0, DV});
    w(`RES2_CYCLES / 2);
    chk({31'h0, powered_down}, 32'h1);
    w(`RES2_CYCLES / 2 + 100);
    chk({31'h0, powered_down}, 32'h0);
  endtask : t_pd_with_id
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  initial
  begin
    w(2);
    rst = 1'b0;
    t_power_up();
    t_std_id();
    t_maker_dev();
    t_release_id();
    t_power_down();
    t_pd_with_id();
    report_and_stop();
  end
  // a hang counts as a mismatch and still reaches the verdict
  initial
  begin
    w(60000);
    err_total++;
    report_and_stop();
  end
endmodule : spi_flash_pd_id_tb
bind spi_flash_pd_id spi_flash_pd_id_chk #(.PUW_CYCLES(PUW_CYCLES)) chk_i (
  .clk_sys(clk_sys), .rst(rst), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .busy(busy),
  .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .powered_down(powered_down),
  .write_ready(write_ready));

// [bench/spi_host_model.sv]
// Purpose: serial host that frames instructions for the flash block
// Assumes: each sck phase lasts 6 clk_sys cycles
// Notes:   drives on falling clk_sys; sck stands low outside frames
`timescale 1ns/1ps
module spi_host_model
  import spi_flash_id_pkg::*;
(
  input  wire logic clk_sys, // system clock
  input  wire logic miso,    // data from the device
  output spi_pins_s pins     // pins to the device
);
  initial
  begin
    pins = '{cs_n: 1'b1, sck: 1'b0, mosi: 1'b0};
  end
  task automatic half(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : half
  // nin bits go out, then nout bits are read at each rising sck
  task automatic frame(input logic [31:0] tx, input int nin, input int nout,
                       output logic [31:0] rx);
    rx = '0;
    half(6);
    pins.cs_n = 1'b0;
    for (int i = 0; i < nin + nout; i++)
    begin
      if (i < nin) pins.mosi = tx[31-i];
      half(6);
      pins.sck = 1'b1;
      if (i >= nin) rx = {rx[30:0], miso};
      half(6);
      pins.sck = 1'b0;
    end
    half(6);
    pins.cs_n = 1'b1;
    pins.mosi = ~pins.mosi; // a released line never shows the last bit
    half(6);
  endtask : frame
endmodule : spi_host_model

// [design/pin_sync.sv]
// Purpose: two-stage synchroniser for asynchronous pins
// Assumes: inputs may change at any time relative to clk_sys
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,  // system clock
  input  wire logic             rst,      // synchronous reset, high
  input  wire logic [WIDTH-1:0] d,        // asynchronous inputs
  output logic      [WIDTH-1:0] q         // synchronised outputs
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  always_comb
  begin
    next_meta = d;
    next_q    = meta;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      meta <= '1;
      q    <= '1;
    end
    else
    begin
      meta <= next_meta;
      q    <= next_q;
    end
  end
endmodule : pin_sync

// [design/spi_flash_id_defs.svh]
// Purpose: shared constants of the power-down and identification block
// Assumes: clk_sys at 200 MHz
// Notes:   times in ns, cycle counts derived from them
`ifndef SPI_FLASH_ID_DEFS_SVH
`define SPI_FLASH_ID_DEFS_SVH

`define CLK_MHZ           200
`define OP_POWER_DOWN     8'hb9
`define OP_RELEASE_ID     8'hab
`define OP_MAKER_DEV_ID   8'h90
`define OP_STD_ID         8'h9f
`define ADDR_SWAP_ORDER   24'h000001
`define OPC_LAST_BIT      6'h07
`define ADDR_LAST_BIT     6'h1f
`define BIT_CNT_MAX       6'h3f
`define OPC_BITS          6'h08
// delays not printed nearby: plain defaults, adjust per process
`define POWER_DOWN_ENTRY_NS   3000
`define RELEASE_RECOVERY_NS   3000
`define RELEASE_RECOVERY2_NS  1800
`define POWER_UP_WRITE_NS     1000000
// least times round up to whole cycles
`define NS_TO_CYC(ns)     ((((ns) * `CLK_MHZ) + 999) / 1000)
`define DP_CYCLES         `NS_TO_CYC(`POWER_DOWN_ENTRY_NS)
`define RES1_CYCLES       `NS_TO_CYC(`RELEASE_RECOVERY_NS)
`define RES2_CYCLES       `NS_TO_CYC(`RELEASE_RECOVERY2_NS)
`define PUW_CYCLES        `NS_TO_CYC(`POWER_UP_WRITE_NS)

`endif

// [design/spi_flash_id_pkg.sv]
// Purpose: types of the power-down and identification block
// Assumes: nothing
// Notes:   constants live in spi_flash_id_defs.svh
package spi_flash_id_pkg;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic mosi;
  } spi_pins_s;

  typedef enum logic [2:0] {
    PH_IDLE   = 3'h0,
    PH_OPCODE = 3'h1,
    PH_ADDR   = 3'h3,
    PH_OUT    = 3'h2,
    PH_DUMMY  = 3'h6,
    PH_HOLD   = 3'h7,
    PH_IGNORE = 3'h5
  } phase_e;

  typedef enum logic [1:0] {
    PWR_NORMAL    = 2'h0,
    PWR_ENTERING  = 2'h1,
    PWR_DOWN      = 2'h3,
    PWR_RELEASING = 2'h2
  } pwr_e;

endpackage : spi_flash_id_pkg

// [design/spi_flash_pd_id.sv]
// Purpose: power-down and identification instruction handling of a serial flash
// Assumes: spi pins oversampled by clk_sys (200 MHz); busy comes from the
//          program/erase engine on clk_sys
// Notes:   identification codes are arbitrary parameters
`timescale 1ns/1ps
`include "spi_flash_id_defs.svh"
module spi_flash_pd_id
  import spi_flash_id_pkg::*;
#(
  parameter logic [7:0] MAKER_ID   = 8'h5a,  // arbitrary value
  parameter logic [7:0] DEVICE_ID  = 8'h13,  // arbitrary value
  parameter logic [7:0] MEM_TYPE   = 8'h30,  // arbitrary value
  parameter logic [7:0] CAPACITY   = 8'h14,  // arbitrary value
  parameter int         PUW_CYCLES = `PUW_CYCLES
) (
  input  wire logic clk_sys,       // system clock
  input  wire logic rst,           // synchronous reset, high (power-up)
  input  wire logic spi_cs_n,      // chip select pin, low active
  input  wire logic spi_sck,       // serial clock pin
  input  wire logic spi_mosi,      // serial data in pin
  input  wire logic busy,          // program/erase/write cycle running
  output logic      spi_miso,      // serial data out
  output logic      spi_miso_oe,   // data out driven while high
  output logic      powered_down,  // device in power-down state
  output logic      write_ready    // write instructions may be accepted
);
  localparam int PUW_W = $clog2(PUW_CYCLES + 1);

  spi_pins_s   pins_raw;
  spi_pins_s   pins;
  logic        sck_prev;
  logic        cs_prev;
  logic        sck_rise;
  logic        sck_fall;
  logic        cs_act;
  logic        cs_rise;

  phase_e      phase;
  pwr_e        pwr;
  logic [5:0]  bit_cnt;
  logic [23:0] shreg;
  logic [7:0]  cmd;
  logic [2:0]  bit_idx;
  logic [1:0]  byte_sel;
  logic [15:0] pwr_cnt;
  logic [PUW_W-1:0] puw_cnt;
  logic [7:0]  cur_byte;
  logic [7:0]  opcode;

  phase_e      next_phase;
  pwr_e        next_pwr;
  logic        next_sck_prev;
  logic        next_cs_prev;
  logic [5:0]  next_bit_cnt;
  logic [23:0] next_shreg;
  logic [7:0]  next_cmd;
  logic [2:0]  next_bit_idx;
  logic [1:0]  next_byte_sel;
  logic [15:0] next_pwr_cnt;
  logic [PUW_W-1:0] next_puw_cnt;
  logic        next_miso;
  logic        next_miso_oe;
  logic        next_powered_down;
  logic        next_write_ready;

  assign pins_raw.cs_n = spi_cs_n;
  assign pins_raw.sck  = spi_sck;
  assign pins_raw.mosi = spi_mosi;

  pin_sync #(
    .WIDTH ($bits(spi_pins_s))
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (pins_raw),
    .q       (pins)
  );

  assign cs_act   = ~pins.cs_n;
  assign cs_rise  = pins.cs_n & ~cs_prev;
  assign sck_rise = pins.sck & ~sck_prev;
  assign sck_fall = ~pins.sck & sck_prev;
  assign opcode   = {shreg[6:0], pins.mosi};

  // byte presented by the current identification sequence
  always_comb
  begin
    cur_byte = DEVICE_ID;
    if (cmd == `OP_MAKER_DEV_ID)
      cur_byte = (byte_sel == 2'h0) ? MAKER_ID : DEVICE_ID;
    else if (cmd == `OP_STD_ID)
    begin
      unique case (byte_sel)
        2'h0:    cur_byte = MAKER_ID;
        2'h1:    cur_byte = MEM_TYPE;
        default: cur_byte = CAPACITY;
      endcase
    end
  end

  always_comb
  begin
    next_phase        = phase;
    next_pwr          = pwr;
    next_sck_prev     = pins.sck;
    next_cs_prev      = pins.cs_n;
    next_bit_cnt      = bit_cnt;
    next_shreg        = shreg;
    next_cmd          = cmd;
    next_bit_idx      = bit_idx;
    next_byte_sel     = byte_sel;
    next_pwr_cnt      = pwr_cnt;
    next_puw_cnt      = puw_cnt;
    next_miso         = spi_miso;
    next_miso_oe      = spi_miso_oe;
    next_write_ready  = write_ready;

    // write gate opens once the power-up delay has run out
    if (puw_cnt != PUW_W'(PUW_CYCLES))
      next_puw_cnt = puw_cnt + PUW_W'(1);
    else
      next_write_ready = 1'b1;

    // timed transitions of the power state
    if (pwr == PWR_ENTERING || pwr == PWR_RELEASING)
    begin
      if (pwr_cnt == 16'h0000)
        next_pwr = (pwr == PWR_ENTERING) ? PWR_DOWN : PWR_NORMAL;
      else
        next_pwr_cnt = pwr_cnt - 16'h0001;
    end

    if (!cs_act)
    begin
      // deselect ends any frame and releases the data pin
      next_phase   = PH_IDLE;
      next_bit_cnt = 6'h00;
      next_miso    = 1'b0;
      next_miso_oe = 1'b0;
      if (cs_rise)
      begin
        if (cmd == `OP_POWER_DOWN && phase == PH_HOLD)
        begin
          next_pwr     = PWR_ENTERING;
          next_pwr_cnt = 16'(`DP_CYCLES - 1);
        end
        else if (cmd == `OP_RELEASE_ID && pwr == PWR_DOWN &&
                 (phase == PH_DUMMY || phase == PH_OUT))
        begin
          next_pwr = PWR_RELEASING;
          // bare opcode is a plain release, longer frames read the ID too
          if (bit_cnt == `OPC_BITS)
            next_pwr_cnt = 16'(`RES1_CYCLES - 1);
          else
            next_pwr_cnt = 16'(`RES2_CYCLES - 1);
        end
      end
    end
    else
    begin
      if (phase == PH_IDLE)
        next_phase = PH_OPCODE;
      if (sck_rise)
      begin
        next_shreg = {shreg[22:0], pins.mosi};
        if (bit_cnt != `BIT_CNT_MAX)
          next_bit_cnt = bit_cnt + 6'h01;
        unique case (phase)
          PH_IDLE, PH_OPCODE:
          begin
            if (bit_cnt == `OPC_LAST_BIT)
            begin
              next_cmd      = opcode;
              next_bit_idx  = 3'h7;
              next_byte_sel = 2'h0;
              next_phase    = PH_IGNORE;
              if (pwr == PWR_ENTERING || pwr == PWR_RELEASING)
                next_phase = PH_IGNORE;
              else if (pwr == PWR_DOWN && opcode != `OP_RELEASE_ID)
                next_phase = PH_IGNORE;
              else if (opcode == `OP_RELEASE_ID && busy)
                next_phase = PH_IGNORE;
              else if (opcode == `OP_RELEASE_ID)
                next_phase = PH_DUMMY;
              else if (opcode == `OP_MAKER_DEV_ID)
                next_phase = PH_ADDR;
              else if (opcode == `OP_STD_ID)
                next_phase = PH_OUT;
              else if (opcode == `OP_POWER_DOWN)
                next_phase = PH_HOLD;
            end
          end
          PH_ADDR, PH_DUMMY:
          begin
            if (bit_cnt == `ADDR_LAST_BIT)
            begin
              next_phase = PH_OUT;
              if (phase == PH_ADDR &&
                  {shreg[22:0], pins.mosi} == `ADDR_SWAP_ORDER)
                next_byte_sel = 2'h1;
            end
          end
          // any clock after the power-down opcode cancels it
          PH_HOLD: next_phase = PH_IGNORE;
          PH_OUT, PH_IGNORE: next_phase = phase;
        endcase
      end
      if (sck_fall && phase == PH_OUT)
      begin
        next_miso    = cur_byte[bit_idx];
        next_miso_oe = 1'b1;
        next_bit_idx = bit_idx - 3'h1;
        if (bit_idx == 3'h0)
        begin
          if (cmd == `OP_MAKER_DEV_ID)
            next_byte_sel = {1'b0, ~byte_sel[0]};
          else if (cmd == `OP_STD_ID)
            next_byte_sel = (byte_sel == 2'h2) ? 2'h0 : byte_sel + 2'h1;
          else
            next_byte_sel = 2'h0;
        end
      end
    end

    next_powered_down = (next_pwr != PWR_NORMAL);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      phase        <= PH_IDLE;
      pwr          <= PWR_NORMAL;
      sck_prev     <= 1'b1;
      cs_prev      <= 1'b1;
      bit_cnt      <= 6'h00;
      shreg        <= 24'h000000;
      cmd          <= 8'h00;
      bit_idx      <= 3'h7;
      byte_sel     <= 2'h0;
      pwr_cnt      <= 16'h0000;
      puw_cnt      <= '0;
      spi_miso     <= 1'b0;
      spi_miso_oe  <= 1'b0;
      powered_down <= 1'b0;
      write_ready  <= 1'b0;
    end
    else
    begin
      phase        <= next_phase;
      pwr          <= next_pwr;
      sck_prev     <= next_sck_prev;
      cs_prev      <= next_cs_prev;
      bit_cnt      <= next_bit_cnt;
      shreg        <= next_shreg;
      cmd          <= next_cmd;
      bit_idx      <= next_bit_idx;
      byte_sel     <= next_byte_sel;
      pwr_cnt      <= next_pwr_cnt;
      puw_cnt      <= next_puw_cnt;
      spi_miso     <= next_miso;
      spi_miso_oe  <= next_miso_oe;
      powered_down <= next_powered_down;
      write_ready  <= next_write_ready;
    end
  end
endmodule : spi_flash_pd_id
